//--- verilog/mplc_pkg.sv
// Package with constants shared by the duty controller and its tables.
package mplc_pkg;
    // Clock and timing.
    localparam int CLK_HZ = 250_000_000;
    localparam int PWM_MAX_HZ = 31_250;
    localparam int PWM_REF_HZ = 8_000;
    localparam int COMP_PERIOD_NS = 380_000;
    localparam int LIMIT_PERIOD_NS = 3_000_000;
    localparam int CLK_PERIOD_NS = 4;
    localparam int COMP_CYCLES = COMP_PERIOD_NS / CLK_PERIOD_NS;
    localparam int LIMIT_CYCLES = LIMIT_PERIOD_NS / CLK_PERIOD_NS;
    // Duty resolution and table geometry.
    localparam int DUTY_W = 8;
    localparam int DUTY_STEPS = 256;
    localparam int VOLT_LEVELS = 32;
    localparam int DUTY_LEVELS = 16;
    localparam int VOLT_Q_W = 5;
    localparam int DUTY_Q_W = 4;
    localparam int CUR_Q_W = 5;
    localparam int COMP_PER_LIMIT = 7;
    // Prescale giving 256 steps per period at the reference frequency.
    localparam int PRESCALE_REF = CLK_HZ / (PWM_REF_HZ * DUTY_STEPS);
    localparam int PRESCALE_MIN = CLK_HZ / (PWM_MAX_HZ * DUTY_STEPS);
    localparam logic [7:0] RELOAD_RESET = 8'h00;
    localparam logic [7:0] DUTY_RESET = 8'h00;
    localparam logic [7:0] DUTY_FULL = 8'hFF;
    // Power limit in watts.
    localparam int POWER_LIMIT_W = 300;
    // Largest duty change per limitation update.
    localparam logic [7:0] LIMIT_SLEW = 8'h04;
endpackage

//--- verilog/mplc_table_rom.sv
// Lookup memory with registered read data.
`timescale 1ns/1ns
module mplc_table_rom #(
    parameter int ADDR_W = 9,
    parameter int DATA_W = 9
) (
    // Clock.
    input wire logic core_clk_i,
    // Table load port.
    input wire logic wr_en_i,
    input wire logic [ADDR_W-1:0] wr_addr_i,
    input wire logic [DATA_W-1:0] wr_data_i,
    // Read port.
    input wire logic [ADDR_W-1:0] rd_addr_i,
    output logic [DATA_W-1:0] rd_data_o
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    always_ff @(posedge core_clk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem[rd_addr_i];
    end
endmodule // mplc_table_rom

//--- verilog/mplc_duty_ctrl.sv
// PWM duty controller with line compensation and power limitation.
`timescale 1ns/1ns
module mplc_duty_ctrl #(
    parameter int COMP_CYCLES = mplc_pkg::COMP_CYCLES,
    parameter int PRESCALE = mplc_pkg::PRESCALE_REF
) (
    // Clock and reset.
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Converter samples, from another domain.
    input wire logic [7:0] dc_link_voltage_i,
    input wire logic [7:0] peak_current_i,
    // Operator settings.
    input wire logic [7:0] requested_duty_i,
    input wire logic [7:0] reload_i,
    input wire logic limit_enable_i,
    // Table loading: sel 0 correction, 1 maximum duty.
    input wire logic tbl_wr_i,
    input wire logic tbl_sel_i,
    input wire logic [8:0] tbl_addr_i,
    input wire logic [8:0] tbl_data_i,
    // Gate drive and status.
    output logic pwm_o,
    output logic [7:0] compare_o,
    output logic limited_o,
    output logic comp_tick_o
);
    typedef enum logic [3:0] {
        MPLC_IDLE = 4'b0001,
        MPLC_LOOK = 4'b0010,
        MPLC_WAIT = 4'b0100,
        MPLC_APPLY = 4'b1000
    } mplc_state_t;

    // Two-flop synchronisers for converter samples and the requested duty.
    logic [7:0] volt_m, volt_s, cur_m, cur_s, req_m, req_s;
    always_ff @(posedge core_clk_i) begin
        volt_m <= dc_link_voltage_i;
        volt_s <= volt_m;
        cur_m <= peak_current_i;
        cur_s <= cur_m;
        req_m <= requested_duty_i;
        req_s <= req_m;
    end

    function automatic logic [7:0] mplc_sat(input logic [9:0] v);
        if (v[9]) begin
            return mplc_pkg::DUTY_RESET;
        end
        if (v[8]) begin
            return mplc_pkg::DUTY_FULL;
        end
        return v[7:0];
    endfunction

    // Scheduler: compensation tick, limitation every seventh tick.
    logic [19:0] comp_cnt;
    logic [2:0] comp_seq;
    logic [7:0] cur_sample;
    wire comp_due = (comp_cnt == 20'(COMP_CYCLES - 1));
    wire limit_due = comp_due &&
        (comp_seq == 3'(mplc_pkg::COMP_PER_LIMIT - 1));
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            comp_cnt <= 20'h0_0000;
            comp_seq <= 3'h0;
            cur_sample <= 8'h00;
        end else begin
            comp_cnt <= comp_due ? 20'h0_0000 : comp_cnt + 20'h0_0001;
            if (comp_due) begin
                comp_seq <= limit_due ? 3'h0 : comp_seq + 3'h1;
            end
            if (limit_due) begin
                cur_sample <= cur_s;
            end
        end
    end

    // Table addresses from quantised inputs.
    logic [7:0] volt_hold, req_hold;
    wire [4:0] volt_q = volt_hold[7:3];
    wire [3:0] duty_q = req_hold[7:4];
    wire [4:0] cur_q = cur_sample[7:3];
    wire [8:0] corr_addr = {volt_q, duty_q};
    // The maximum table drops the lowest voltage bit so that every entry
    // stays reachable through the 9-bit load port; a read of an entry that
    // was never loaded would poison the limiter until the next reset.
    wire [8:0] max_addr = {volt_q[4:1], cur_q};
    logic [8:0] corr_data;
    logic [8:0] max_data;
    mplc_table_rom #(.ADDR_W(9), .DATA_W(9)) u_corr (
        .core_clk_i(core_clk_i),
        .wr_en_i(tbl_wr_i && !tbl_sel_i),
        .wr_addr_i(tbl_addr_i),
        .wr_data_i(tbl_data_i),
        .rd_addr_i(corr_addr),
        .rd_data_o(corr_data)
    );
    // Maximum duty table holds power limit over volts times amps.
    mplc_table_rom #(.ADDR_W(9), .DATA_W(9)) u_max (
        .core_clk_i(core_clk_i),
        .wr_en_i(tbl_wr_i && tbl_sel_i),
        .wr_addr_i(tbl_addr_i),
        .wr_data_i(tbl_data_i),
        .rd_addr_i(max_addr),
        .rd_data_o(max_data)
    );

    // Update sequence.
    mplc_state_t state, next_state;
    logic do_limit;
    logic [7:0] limit_duty, pend_cmp;
    logic pend_valid;
    always_comb begin
        next_state = state;
        unique case (state)
            MPLC_IDLE: if (comp_due) next_state = MPLC_LOOK;
            MPLC_LOOK: next_state = MPLC_WAIT;
            MPLC_WAIT: next_state = MPLC_APPLY;
            MPLC_APPLY: next_state = MPLC_IDLE;
            default: next_state = MPLC_IDLE;
        endcase
    end

    // Correction is a signed 9-bit value added to the request.
    wire [9:0] corr_sum = {2'b00, req_hold} +
        {corr_data[8], corr_data};
    wire [7:0] comp_duty = mplc_sat(corr_sum);
    wire [7:0] max_duty = max_data[8] ? mplc_pkg::DUTY_FULL : max_data[7:0];
    // Slew toward the maximum so limiting engages and releases gently.
    // The threshold is nine bits wide so a maximum near full cannot wrap.
    wire [8:0] lim_thr = {1'b0, max_duty} + {1'b0, mplc_pkg::LIMIT_SLEW};
    wire [7:0] lim_down = ({1'b0, limit_duty} > lim_thr) ?
        limit_duty - mplc_pkg::LIMIT_SLEW : max_duty;
    wire [8:0] lim_up_w = {1'b0, limit_duty} + {1'b0, mplc_pkg::LIMIT_SLEW};
    wire [7:0] lim_up = (lim_up_w[8] || lim_up_w[7:0] > max_duty) ?
        max_duty : lim_up_w[7:0];
    wire [7:0] next_limit = (limit_duty > max_duty) ? lim_down : lim_up;
    wire [7:0] capped = (limit_enable_i && comp_duty > limit_duty) ?
        limit_duty : comp_duty;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state <= MPLC_IDLE;
            do_limit <= 1'b0;
            volt_hold <= 8'h00;
            req_hold <= 8'h00;
            limit_duty <= mplc_pkg::DUTY_FULL;
        end else begin
            state <= next_state;
            if (state == MPLC_IDLE && comp_due) begin
                volt_hold <= volt_s;
                req_hold <= req_s;
                do_limit <= limit_due;
            end
            if (state == MPLC_APPLY) begin
                if (do_limit) begin
                    limit_duty <= next_limit;
                end
            end
        end
    end

    // PWM timer: prescaler, 8-bit up counter, autoreload.
    logic [15:0] pre_cnt;
    logic [7:0] pwm_cnt;
    wire step = (pre_cnt == 16'(PRESCALE - 1));
    wire term = step && (pwm_cnt == mplc_pkg::DUTY_FULL);
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pre_cnt <= 16'h0000;
            pwm_cnt <= mplc_pkg::RELOAD_RESET;
            compare_o <= mplc_pkg::DUTY_RESET;
            pend_cmp <= mplc_pkg::DUTY_RESET;
            pend_valid <= 1'b0;
            pwm_o <= 1'b0;
            limited_o <= 1'b0;
            comp_tick_o <= 1'b0;
        end else begin
            pre_cnt <= step ? 16'h0000 : pre_cnt + 16'h0001;
            if (state == MPLC_APPLY) begin
                // The new duty waits here until the running period ends.
                pend_cmp <= capped;
                pend_valid <= 1'b1;
            end else if (term) begin
                pend_valid <= 1'b0;
            end
            if (term) begin
                pwm_cnt <= reload_i;
                if (pend_valid) begin
                    compare_o <= pend_cmp;
                end
            end else if (step) begin
                pwm_cnt <= pwm_cnt + 8'h01;
            end
            // High while the count is above 0xFF minus the compare value;
            // 0xFF gives always high and 0x00 always low.
            pwm_o <= (compare_o == mplc_pkg::DUTY_FULL) ||
                (compare_o != mplc_pkg::DUTY_RESET &&
                 (8'hFF - pwm_cnt) < compare_o);
            limited_o <= limit_enable_i && (limit_duty < mplc_pkg::DUTY_FULL);
            comp_tick_o <= (state == MPLC_APPLY);
        end
    end
endmodule // mplc_duty_ctrl

//--- testbench/mplc_checker.sv
// Port checker for the duty controller.
`timescale 1ns/1ns
module mplc_checker #(
    parameter int COMP_CYCLES = mplc_pkg::COMP_CYCLES
) (
    // Clock and reset.
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Inputs watched.
    input wire logic [7:0] reload_i,
    input wire logic limit_enable_i,
    // Outputs watched.
    input wire logic pwm_o,
    input wire logic [7:0] compare_o,
    input wire logic limited_o,
    input wire logic comp_tick_o
);
    logic [19:0] gap;
    logic seen;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    // The first tick after reset has no reference, so spacing waits for two.
    always_ff @(posedge core_clk_i) begin
        gap <= comp_tick_o ? 20'h0_0000 : gap + 20'h0_0001;
        seen <= !rst_i && (seen || comp_tick_o);
    end
    sequence s_tick;
        comp_tick_o ##1 !comp_tick_o;
    endsequence
    a_reset_quiet: assert property ($fell(rst_i) |-> !pwm_o &&
        compare_o == 8'h00 && !limited_o && !comp_tick_o)
        else $error("outputs not idle after reset");
    a_tick_pulse: assert property (comp_tick_o |-> s_tick)
        else $error("update tick longer than one cycle");
    a_tick_spacing: assert property (comp_tick_o && seen |->
        gap == COMP_CYCLES - 1) else $error("update spacing wrong");
    a_zero_low: assert property (compare_o == 8'h00 &&
        $past(compare_o) == 8'h00 |-> !pwm_o)
        else $error("gate high with zero compare");
    a_cmp_hold: assert property ($changed(compare_o) &&
        reload_i < 8'hF0 |=> $stable(compare_o) [*8])
        else $error("compare changed inside a period");
    a_limit_off: assert property (!limit_enable_i [*5] |->
        !limited_o) else $error("limited while limit disabled");
    // With the enable already high, only a limiter update can raise it.
    a_limit_tick: assert property ($rose(limited_o) &&
        $past(limit_enable_i, 2) |-> $past(comp_tick_o))
        else $error("limit began off update");
    a_limit_gentle: assert property ($changed(compare_o) &&
        limited_o && $past(limited_o) |->
        8'(compare_o - $past(compare_o) + 8'h04) <= 8'h08)
        else $error("limited duty jumped");
endmodule // mplc_checker

bind mplc_duty_ctrl mplc_checker #(.COMP_CYCLES(COMP_CYCLES)) u_chk (
    .core_clk_i, .rst_i, .reload_i, .limit_enable_i, .pwm_o, .compare_o,
    .limited_o, .comp_tick_o);

//--- testbench/mplc_gate_model.sv
// Gate driver model that counts the cycles the chopper is on.
`timescale 1ns/1ns
module mplc_gate_model (
    // Clock and clear.
    input wire logic core_clk_i,
    input wire logic clr_i,
    // Gate drive.
    input wire logic pwm_i,
    // High cycles since clear.
    output logic [15:0] hi_cnt_o
);
    always_ff @(posedge core_clk_i) begin
        if (clr_i) begin
            hi_cnt_o <= 16'h0000;
        end else if (pwm_i) begin
            hi_cnt_o <= hi_cnt_o + 16'h0001;
        end
    end
endmodule // mplc_gate_model

//--- testbench/tb.sv
// Self-checking bench for the duty controller.
`timescale 1ns/1ns
module tb;
    logic core_clk_i = 0;
    logic rst_i = 1;
    logic [7:0] volt = 8'h80;
    logic [7:0] cur = 8'hF8;
    logic [7:0] req = 8'h00;
    logic [7:0] rel = 8'h00;
    logic lim_en = 0;
    logic wr = 0;
    logic sel = 0;
    logic clr = 1;
    logic [8:0] addr = 9'h000;
    logic [8:0] data = 9'h000;
    logic pwm, lim, tick;
    logic [7:0] cmp;
    logic [15:0] hi;
    int n_mismatch = 0;
    int n_checks = 0;
    always #2 core_clk_i = ~core_clk_i;
    mplc_duty_ctrl #(.COMP_CYCLES(50), .PRESCALE(1)) dut (
        .core_clk_i, .rst_i, .dc_link_voltage_i(volt), .peak_current_i(cur),
        .requested_duty_i(req), .reload_i(rel), .limit_enable_i(lim_en),
        .tbl_wr_i(wr), .tbl_sel_i(sel), .tbl_addr_i(addr), .tbl_data_i(data),
        .pwm_o(pwm), .compare_o(cmp), .limited_o(lim), .comp_tick_o(tick));
    mplc_gate_model gate (.core_clk_i, .clr_i(clr), .pwm_i(pwm),
        .hi_cnt_o(hi));
    task automatic check(input logic [15:0] s, input logic [15:0] e);
        n_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h want %h", $time, s, e);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic put(input logic s, input logic [8:0] a, input logic [8:0] d);
        @(negedge core_clk_i);
        wr = 1;
        sel = s;
        addr = a;
        data = d;
        @(negedge core_clk_i);
        wr = 0;
    endtask
    // Two ticks and a full period let a new duty reach the compare.
    task automatic apply(input logic [7:0] r, input logic [7:0] e);
        int n;
        req = r;
        n = 2;
        for (int k = 0; k < 5000 && n > 0; k++) begin
            @(negedge core_clk_i);
            if (tick === 1'b1) n--;
        end
        if (n > 0) begin
            n_mismatch++;
            report_and_stop();
        end
        repeat (300) @(negedge core_clk_i);
        check({8'h00, cmp}, {8'h00, e});
    endtask
    task automatic meas(input logic [15:0] e);
        clr = 1;
        @(negedge core_clk_i);
        clr = 0;
        repeat (256) @(negedge core_clk_i);
        check(hi, e);
    endtask
    // Tables are not reset, so they are filled and the logic reset again.
    task automatic t_load();
        for (int i = 0; i < 512; i++) begin
            put(1'b0, 9'(i), 9'h000);
            put(1'b1, 9'(i), 9'h100);
        end
        rst_i = 1;
        repeat (2) @(negedge core_clk_i);
        rst_i = 0;
    endtask
    task automatic t_span();
        apply(8'h00, 8'h00);
        meas(16'h0000);
        apply(8'h40, 8'h40);
        meas(16'h0040);
        rel = 8'h80;
        repeat (300) @(negedge core_clk_i);
        meas(16'h0080);
        rel = 8'h00;
        apply(8'hFF, 8'hFF);
        meas(16'h0100);
    endtask
    task automatic t_corr();
        put(1'b0, 9'h104, 9'h010);
        apply(8'h40, 8'h50);
        apply(8'h4F, 8'h5F);
        put(1'b0, 9'h10F, 9'h010);
        apply(8'hF8, 8'hFF);
        put(1'b0, 9'h101, 9'h1E0);
        apply(8'h10, 8'h00);
    endtask
    task automatic t_limit();
        logic [7:0] p;
        put(1'b1, 9'h11F, 9'h020);
        apply(8'h60, 8'h60);
        lim_en = 1;
        p = cmp;
        for (int k = 0; k < 40000 && cmp !== 8'h20; k++) begin
            @(negedge core_clk_i);
            if (cmp !== p) check(16'(8'(p - cmp) <= 8'h04), 16'h0001);
            p = cmp;
        end
        check({8'h00, cmp}, 16'h0020);
        if (cmp !== 8'h20) report_and_stop();
        check({15'h0000, lim}, 16'h0001);
        lim_en = 0;
        repeat (8) @(negedge core_clk_i);
        check({15'h0000, lim}, 16'h0000);
    endtask
    // A reset restores the limiter to full; the seventh update lowers it.
    task automatic t_relimit();
        int n;
        lim_en = 1;
        rst_i = 1;
        repeat (3) @(negedge core_clk_i);
        rst_i = 0;
        n = 0;
        check({15'h0000, lim}, 16'h0000);
        for (int k = 0; k < 1000 && lim !== 1'b1; k++) begin
            @(negedge core_clk_i);
            if (tick === 1'b1) n++;
        end
        check(16'(n), 16'h0007);
        check({15'h0000, lim}, 16'h0001);
    endtask
    initial begin
        repeat (10) @(negedge core_clk_i);
        rst_i = 0;
        t_load();
        t_span();
        t_corr();
        t_limit();
        t_relimit();
        report_and_stop();
    end
endmodule // tb
